/* design/tcs_pin_status.sv */
// Purpose: Pin-level control and status of a Type-C source port
// Assumes: Connection facts come from the state machine on clk; pins are async
// Notes:   Every output is registered; pins lag conn by one edge, async pins by three
`timescale 1ns/1ps
`default_nettype none

module tcs_pin_status (
  input  wire logic                clk,                     // 250 MHz clock
  input  wire logic                sys_rst,                 // Sync reset, high
  input  wire logic                ce,                      // Freezes state when low
  input  wire logic                default_current_select,  // Async pin
  input  wire logic                high_current_select,     // Async pin
  input  wire logic                vbus_monitor_input,      // Async VBUS presence
  input  wire logic                vbus_window_ok,          // Async range comparator
  input  wire logic                bus_address_select,      // Async address strap
  input  wire tcs_pkg::tcs_conn_s  conn,                    // State machine facts
  output var  tcs_pkg::tcs_pins_s  pins,                    // Open-drain pins
  output var  tcs_pkg::tcs_status_s status,                 // Register mirrors
  output var  tcs_pkg::tcs_adv_e   rp_level,                // Pull-up on CC
  output var  tcs_pkg::tcs_vconn_s vconn_route,             // VCONN switches
  output logic                     address_bit              // Synced address bit
);

  // ============================================================
  // State
  // ============================================================

  // Whole module state in one record
  typedef struct packed {
    logic [tcs_pkg::PIN_W-1:0] sync1;       // First sync stage
    logic [tcs_pkg::PIN_W-1:0] sync2;       // Second sync stage
    tcs_pkg::tcs_adv_e         adv;         // Advertised level
    logic                      vbus_ok;     // Vbus_in_range_n asserted
    logic                      attached;    // Attach asserted
    logic                      accessory;   // Accessory asserted
    logic                      cc2;         // CC2 orientation
    logic                      path_on;     // Power path on
    logic                      alert;       // Interrupt asserted
    logic                      vconn_cc1;   // VCONN onto CC1
    logic                      vconn_cc2;   // VCONN onto CC2
    logic                      addr;        // Address bit
  } tcs_state_s;

  tcs_state_s state;       // Registered state
  tcs_state_s next_state;  // Next value

  // ============================================================
  // Functions
  // ============================================================

  // Map the two select levels onto a pull-up level
  function automatic tcs_pkg::tcs_adv_e adv_decode(input logic def_sel,
                                                   input logic high_sel);
    tcs_pkg::tcs_adv_e lvl;
    lvl = tcs_pkg::TCS_ADV_USB_DEFAULT;
    if (!def_sel)
    begin
      lvl = tcs_pkg::TCS_ADV_USB_DEFAULT;
    end
    else if (!high_sel)
    begin
      lvl = tcs_pkg::TCS_ADV_TYPEC_MEDIUM;
    end
    else
    begin
      lvl = tcs_pkg::TCS_ADV_TYPEC_HIGH;
    end
    return lvl;
  endfunction : adv_decode

  // Open-drain drive: pull low while asserted, else release
  function automatic tcs_pkg::tcs_od_s od_drive(input logic active);
    tcs_pkg::tcs_od_s p;
    p.out = tcs_pkg::OD_PULL_LEVEL;
    p.oe  = active;
    return p;
  endfunction : od_drive

  // ============================================================
  // Next-state logic
  // ============================================================

  // Decoded conditions from synced pins and connection facts
  logic vbus_present;   // Present and inside the window
  logic fault;          // Error recovery blocks every indication but the alert
  logic sink_ok;        // Sink connection not in fault
  logic acc_ok;         // Accessory not in fault

  // Combinational next value of the whole state
  always_comb
  begin
    next_state   = state;
    vbus_present = state.sync2[tcs_pkg::PIN_VBUS_LIVE]
                   && state.sync2[tcs_pkg::PIN_VBUS_RANGE];
    fault        = conn.error_recovery;
    sink_ok      = conn.sink_attached && !fault;
    acc_ok       = (conn.audio_accessory || conn.debug_accessory) && !fault;

    // Two-flop synchronisers; only stage two is read below
    // Each pin lands at its named slot, so a reorder cannot swap pins
    next_state.sync1[tcs_pkg::PIN_DEF_SEL]    = default_current_select;
    next_state.sync1[tcs_pkg::PIN_HIGH_SEL]   = high_current_select;
    next_state.sync1[tcs_pkg::PIN_VBUS_LIVE]  = vbus_monitor_input;
    next_state.sync1[tcs_pkg::PIN_VBUS_RANGE] = vbus_window_ok;
    next_state.sync1[tcs_pkg::PIN_ADDR_SEL]   = bus_address_select;
    next_state.sync2 = state.sync1;

    // Pull-up follows the selects every cycle, so run-time changes land
    next_state.adv = adv_decode(state.sync2[tcs_pkg::PIN_DEF_SEL],
                                state.sync2[tcs_pkg::PIN_HIGH_SEL]);

    // Vbus_in_range_n only while attaching a sink with VBUS in the window
    next_state.vbus_ok = sink_ok && vbus_present;

    // Attach covers sinks and accessories alike
    next_state.attached = sink_ok || acc_ok;

    // Either accessory kind raises the accessory output
    next_state.accessory = acc_ok;

    // Orientation only means something while attached
    next_state.cc2 = (sink_ok || acc_ok) && conn.cc2_active;

    // Power path needs a sink and VBUS in range
    next_state.path_on = sink_ok && vbus_present;

    // VCONN goes to whichever CC pin is not the CC line
    if (sink_ok && conn.vconn_enable)
    begin
      next_state.vconn_cc1 = conn.cc2_active;
      next_state.vconn_cc2 = !conn.cc2_active;
    end
    else
    begin
      // Switches open off a connection
      next_state.vconn_cc1 = tcs_pkg::BIT_CLR;
      next_state.vconn_cc2 = tcs_pkg::BIT_CLR;
    end

    // Interrupt request from the register file
    next_state.alert = conn.alert_request;

    // Address strap assumed static by the host
    next_state.addr = state.sync2[tcs_pkg::PIN_ADDR_SEL];
  end

  // ============================================================
  // State register
  // ============================================================

  // Reset wins over clock enable so the block always starts clean
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      // Reset holds every indication released
      state.sync1     <= tcs_pkg::PIN_RST;
      state.sync2     <= tcs_pkg::PIN_RST;
      state.adv       <= tcs_pkg::TCS_ADV_USB_DEFAULT;
      state.vbus_ok   <= tcs_pkg::BIT_CLR;
      state.attached  <= tcs_pkg::BIT_CLR;
      state.accessory <= tcs_pkg::BIT_CLR;
      state.cc2       <= tcs_pkg::BIT_CLR;
      state.path_on   <= tcs_pkg::BIT_CLR;
      state.alert     <= tcs_pkg::BIT_CLR;
      state.vconn_cc1 <= tcs_pkg::BIT_CLR;
      state.vconn_cc2 <= tcs_pkg::BIT_CLR;
      state.addr      <= tcs_pkg::BIT_CLR;
    end
    else if (ce)
    begin
      // Normal operation
      state <= next_state;
    end
  end

  // ============================================================
  // Outputs
  // ============================================================

  // Pins and mirrors straight from the state flops
  always_comb
  begin
    pins.alert                      = od_drive(state.alert);
    pins.vbus_in_range_n            = od_drive(state.vbus_ok);
    pins.attach                     = od_drive(state.attached);
    pins.accessory_found_n          = od_drive(state.accessory);
    pins.orientation                = od_drive(state.cc2);
    pins.source_power_path_enable_n = od_drive(state.path_on);

    // Mirrors read the same flops as the pins, so they never disagree
    status.vbus_good            = state.vbus_ok;
    status.attached             = state.attached;
    status.accessory            = state.accessory;
    status.cc2_orientation      = state.cc2;
    status.power_path_pin_level = !state.path_on;

    rp_level           = state.adv;
    vconn_route.to_cc1 = state.vconn_cc1;
    vconn_route.to_cc2 = state.vconn_cc2;
    address_bit        = state.addr;
  end

  // ============================================================
  // Assertions
  // ============================================================

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // Reset releases the attach and power-path pins one edge later
  a_reset_releases_pins: assert property (
    @(posedge clk) disable iff (1'b0)
    sys_rst |=> (pins.attach.oe == 1'b0) && (pins.source_power_path_enable_n.oe == 1'b0))
    else $error("pins not released after reset");

  a_alert_follows_req: assert property (
    ce && conn.alert_request |=> pins.alert.oe && (pins.alert.out == 1'b0))
    else $error("alert not pulled low");

  // Any missing cause keeps the VBUS indication released
  a_vbus_ok_cause: assert property (
    ce && !(conn.sink_attached && !conn.error_recovery
            && state.sync2[tcs_pkg::PIN_VBUS_LIVE]
            && state.sync2[tcs_pkg::PIN_VBUS_RANGE])
    |=> !pins.vbus_in_range_n.oe)
    else $error("vbus_in_range_n without cause");

  a_vbus_mirror_match: assert property (
    status.vbus_good == pins.vbus_in_range_n.oe)
    else $error("vbus mirror differs");

  a_attach_sink_acc: assert property (
    ce && !conn.error_recovery
    && (conn.sink_attached || conn.audio_accessory || conn.debug_accessory)
    |=> pins.attach.oe && status.attached)
    else $error("attach missing");

  a_attach_od_level: assert property (
    pins.attach.out == 1'b0 && pins.accessory_found_n.out == 1'b0)
    else $error("open drain drives high");

  // Expected level spelt out here, apart from the decode function
  a_adv_tracks_sel: assert property (
    ce ##1 ce ##1 ce && $stable(default_current_select) && $stable(high_current_select)
    && $past(default_current_select, 2) == default_current_select
    && $past(high_current_select, 2) == high_current_select
    |=> rp_level == (!$past(default_current_select, 3) ? tcs_pkg::TCS_ADV_USB_DEFAULT
                     : $past(high_current_select, 3) ? tcs_pkg::TCS_ADV_TYPEC_HIGH
                     : tcs_pkg::TCS_ADV_TYPEC_MEDIUM))
    else $error("pull-up level wrong");

  a_orient_cc1_hiz: assert property (
    ce && !conn.cc2_active |=> !pins.orientation.oe && !status.cc2_orientation)
    else $error("orientation driven for cc1");

  a_vconn_unused_pin: assert property (
    ce && conn.sink_attached && !conn.error_recovery && conn.vconn_enable
    |=> (vconn_route.to_cc1 == $past(conn.cc2_active))
        && (vconn_route.to_cc2 != $past(conn.cc2_active)))
    else $error("vconn on wrong pin");

  a_path_needs_vbus: assert property (
    pins.source_power_path_enable_n.oe |-> pins.vbus_in_range_n.oe
    && (status.power_path_pin_level == 1'b0))
    else $error("power path without valid vbus");

  a_fault_releases: assert property (
    ce && conn.error_recovery |=> !pins.attach.oe && !pins.source_power_path_enable_n.oe
    && !pins.accessory_found_n.oe)
    else $error("fault did not release pins");

  // Positive side of the power path: sink plus VBUS pulls the pin low
  a_path_pulls_low: assert property (
    ce && conn.sink_attached && !conn.error_recovery
    && state.sync2[tcs_pkg::PIN_VBUS_LIVE] && state.sync2[tcs_pkg::PIN_VBUS_RANGE]
    |=> pins.source_power_path_enable_n.oe
        && (pins.source_power_path_enable_n.out == tcs_pkg::OD_PULL_LEVEL))
    else $error("power path not pulled low");

  // Either accessory kind raises the accessory pin and its mirror
  a_accessory_seen: assert property (
    ce && !conn.error_recovery && (conn.audio_accessory || conn.debug_accessory)
    |=> pins.accessory_found_n.oe && status.accessory)
    else $error("accessory not flagged");

  // No accessory, no pull on the accessory pin
  a_accessory_released: assert property (
    ce && !conn.audio_accessory && !conn.debug_accessory |=> !pins.accessory_found_n.oe)
    else $error("accessory pin held without accessory");

  // CC2 orientation drives the pin low and sets the mirror
  a_orient_cc2_low: assert property (
    ce && conn.sink_attached && !conn.error_recovery && conn.cc2_active
    |=> pins.orientation.oe && (pins.orientation.out == 1'b0) && status.cc2_orientation)
    else $error("orientation not low for cc2");

  // Nobody on the port: attach pin and mirror both released
  a_attach_released: assert property (
    ce && !conn.sink_attached && !conn.audio_accessory && !conn.debug_accessory
    |=> !pins.attach.oe && !status.attached)
    else $error("attach held after detach");

  // Default select low wins whatever the high select says
  a_rp_default_sel: assert property (
    ce ##1 ce ##1 (ce && !$past(default_current_select, 2))
    |=> rp_level == tcs_pkg::TCS_ADV_USB_DEFAULT)
    else $error("default current not advertised");

  // Interrupt line let go once the request is gone
  a_alert_released: assert property (
    ce && !conn.alert_request |=> !pins.alert.oe)
    else $error("alert held without request");

  // VCONN switches open unless an attached sink out of error recovery asks for them
  a_vconn_off: assert property (
    ce && !(conn.sink_attached && !conn.error_recovery && conn.vconn_enable)
    |=> !vconn_route.to_cc1 && !vconn_route.to_cc2)
    else $error("vconn on without cause");

  // Main scenarios
  c_fault_exit:    cover property (pins.attach.oe && conn.error_recovery ##1 !pins.attach.oe);
  c_sink_powered:  cover property (pins.source_power_path_enable_n.oe ##1 !pins.attach.oe);
  c_accessory:     cover property (pins.accessory_found_n.oe && pins.attach.oe);
  c_cc2_vconn:     cover property (pins.orientation.oe && vconn_route.to_cc1);
  c_high_current:  cover property (rp_level == tcs_pkg::TCS_ADV_TYPEC_HIGH);

endmodule : tcs_pin_status

`default_nettype wire

/* design/tcs_pkg.sv */
// Purpose: Shared types and constants for the Type-C source pin status block
// Assumes: One 250 MHz clock, synchronous active-high reset
// Notes:   Open-drain pins travel as out/oe pairs; the wire level is resolved outside

// ============================================================
// Package
// ============================================================
package tcs_pkg;

  // Clock period, kept for reference by users of the block
  localparam int CLK_PERIOD_NS = 4;

  // Number of flip-flops in each pin synchroniser
  localparam int SYNC_STAGES = 2;

  // Bit positions of the asynchronous pin inputs in the sync vector
  localparam int PIN_W           = 5;
  localparam int PIN_DEF_SEL     = 0;  // Default-current select
  localparam int PIN_HIGH_SEL    = 1;  // High-current select
  localparam int PIN_VBUS_LIVE   = 2;  // VBUS presence on the monitor input
  localparam int PIN_VBUS_RANGE  = 3;  // VBUS window comparator result
  localparam int PIN_ADDR_SEL    = 4;  // Bus address select strap

  // Reset value of the sync vector
  localparam logic [PIN_W-1:0] PIN_RST = 5'h00;

  // Level an open-drain pin pulls to while enabled
  localparam logic OD_PULL_LEVEL = 1'b0;

  // Single-bit reset values
  localparam logic BIT_CLR = 1'b0;
  localparam logic BIT_SET = 1'b1;

  // Advertised pull-up level on CC
  typedef enum logic [1:0] {
    TCS_ADV_USB_DEFAULT,
    TCS_ADV_TYPEC_MEDIUM,
    TCS_ADV_TYPEC_HIGH
  } tcs_adv_e;

  // One open-drain pin: output level and output enable
  typedef struct packed {
    logic out;
    logic oe;
  } tcs_od_s;

  // Connection facts from the Type-C state machine (same clock)
  typedef struct packed {
    logic sink_attached;    // Valid source-to-sink connection
    logic audio_accessory;  // Audio accessory seen
    logic debug_accessory;  // Debug accessory seen
    logic cc2_active;       // CC2 carries the CC line
    logic error_recovery;   // Error recovery in progress
    logic vconn_enable;     // VCONN switches enabled
    logic alert_request;    // Interrupt pending in the register file
  } tcs_conn_s;

  // All open-drain pins of the port
  typedef struct packed {
    tcs_od_s alert;
    tcs_od_s vbus_in_range_n;
    tcs_od_s attach;
    tcs_od_s accessory_found_n;
    tcs_od_s orientation;
    tcs_od_s source_power_path_enable_n;
  } tcs_pins_s;

  // Status bits mirrored to the register file
  typedef struct packed {
    logic vbus_good;
    logic attached;
    logic accessory;
    logic cc2_orientation;
    logic power_path_pin_level;  // Logic level of the power-path pin
  } tcs_status_s;

  // VCONN steering
  typedef struct packed {
    logic to_cc1;
    logic to_cc2;
  } tcs_vconn_s;

endpackage : tcs_pkg

/* dv/tcs_port_partner.sv */
// Purpose: Far-side model of the port: attached party, state machine facts, pull-ups
// Assumes: The bench picks the attached party just after a clock edge
// Notes:   A released open-drain line reads high, never the last driven level
`timescale 1ns/1ps
`default_nettype none

module tcs_port_partner (
  input  wire logic [1:0]         party,      // 0 none, 1 sink, 2 audio, 3 debug
  input  wire logic               flip,       // Plug turned, CC line on CC2
  input  wire logic [2:0]         ctl,        // Error recovery, VCONN enable, alert
  input  wire tcs_pkg::tcs_pins_s pins,       // Open-drain pins of the block
  output var  tcs_pkg::tcs_conn_s conn,       // Facts handed to the block
  output logic [5:0]              wire_level  // Resolved levels, pin order
);

  // ============================================================
  // Pull-up resolution
  // ============================================================
  // External pull-up wins whenever nobody pulls the line
  function automatic logic lvl(input tcs_pkg::tcs_od_s p);
    return p.oe ? p.out : 1'b1;
  endfunction : lvl

  // Line levels as the outside world sees them
  always_comb
  begin
    wire_level = {lvl(pins.alert), lvl(pins.vbus_in_range_n), lvl(pins.attach),
                  lvl(pins.accessory_found_n), lvl(pins.orientation),
                  lvl(pins.source_power_path_enable_n)};
  end

  // ============================================================
  // Connection facts
  // ============================================================
  // Only one kind of party at a time, as a real plug allows
  always_comb
  begin
    conn                 = '0;
    conn.sink_attached   = (party == 2'h1);
    conn.audio_accessory = (party == 2'h2);
    conn.debug_accessory = (party == 2'h3);
    conn.cc2_active      = flip;
    conn.error_recovery  = ctl[2];
    conn.vconn_enable    = ctl[1];
    conn.alert_request   = ctl[0];
  end

endmodule : tcs_port_partner

`default_nettype wire

/* dv/typec_source_pin_status_control_tb.sv */
// Purpose: Self-checking bench for the Type-C source pin status block
// Assumes: Inputs change 1 ns after a rising edge; async pins settle in 3 edges
// Notes:   Table rows cover the ordinary cases, hand tests the timing corners
`timescale 1ns/1ps
`default_nettype none

module typec_source_pin_status_control_tb;

  // ============================================================
  // Row layout: stimulus beside expected outputs
  // ============================================================
  typedef struct packed {
    logic [1:0]       party;  // Attached party
    logic             flip;   // CC on CC2
    logic [2:0]       ctl;    // Error, VCONN enable, alert
    logic [1:0]       sel;    // Default select, high select
    logic [1:0]       vb;     // Sense, window
    logic [5:0]       w;      // Expected line levels
    logic [4:0]       st;     // Expected status
    tcs_pkg::tcs_adv_e rp;    // Expected pull-up
    logic [1:0]       vc;     // Expected VCONN route
  } tcs_row_s;

  localparam tcs_row_s ROWS [8] = '{
    '{2'h0, 1'b0, 3'h0, 2'h1, 2'h0, 6'h3f, 5'h01, tcs_pkg::TCS_ADV_USB_DEFAULT, 2'h0},
    '{2'h1, 1'b0, 3'h2, 2'h2, 2'h3, 6'h26, 5'h18, tcs_pkg::TCS_ADV_TYPEC_MEDIUM, 2'h1},
    '{2'h1, 1'b1, 3'h3, 2'h3, 2'h3, 6'h04, 5'h1a, tcs_pkg::TCS_ADV_TYPEC_HIGH, 2'h2},
    '{2'h1, 1'b1, 3'h0, 2'h1, 2'h2, 6'h35, 5'h0b, tcs_pkg::TCS_ADV_USB_DEFAULT, 2'h0},
    '{2'h2, 1'b0, 3'h0, 2'h3, 2'h3, 6'h33, 5'h0d, tcs_pkg::TCS_ADV_TYPEC_HIGH, 2'h0},
    '{2'h3, 1'b1, 3'h2, 2'h2, 2'h3, 6'h31, 5'h0f, tcs_pkg::TCS_ADV_TYPEC_MEDIUM, 2'h0},
    '{2'h1, 1'b1, 3'h6, 2'h0, 2'h3, 6'h3f, 5'h01, tcs_pkg::TCS_ADV_USB_DEFAULT, 2'h0},
    '{2'h1, 1'b0, 3'h0, 2'h3, 2'h1, 6'h37, 5'h09, tcs_pkg::TCS_ADV_TYPEC_HIGH, 2'h0}
  };

  // ============================================================
  // Signals
  // ============================================================
  logic                clk = 1'b0;      // 250 MHz
  logic                sys_rst = 1'b1;  // Held for two cycles at start
  logic                ce = 1'b1;       // Block enabled except in the clock-enable test
  logic [1:0]          sel = 2'h0;      // Current select pins
  logic [1:0]          vb = 2'h0;       // Vbus_monitor_input and window
  logic                addr = 1'b0;     // Address strap
  logic [1:0]          party = 2'h0;    // Far-side party
  logic                flip = 1'b0;     // Orientation
  logic [2:0]          ctl = 3'h0;      // Error, VCONN, alert
  tcs_pkg::tcs_conn_s  conn;            // From partner
  tcs_pkg::tcs_pins_s  pins;            // Open-drain pins
  tcs_pkg::tcs_status_s status;         // Status mirrors
  tcs_pkg::tcs_adv_e   rp_level;        // Advertised pull-up
  tcs_pkg::tcs_vconn_s vconn_route;     // VCONN switches
  logic                address_bit;     // Synced strap
  logic [5:0]          wire_level;      // Resolved lines
  int                  num_errors = 0;
  int                  samples_checked = 0;

  always #(tcs_pkg::CLK_PERIOD_NS / 2) clk = ~clk;

  // ============================================================
  // Design and far side
  // ============================================================
  tcs_pin_status dut (
    .clk(clk), .sys_rst(sys_rst), .ce(ce),
    .default_current_select(sel[1]), .high_current_select(sel[0]),
    .vbus_monitor_input(vb[1]), .vbus_window_ok(vb[0]),
    .bus_address_select(addr), .conn(conn), .pins(pins), .status(status),
    .rp_level(rp_level), .vconn_route(vconn_route), .address_bit(address_bit)
  );

  tcs_port_partner partner (
    .party(party), .flip(flip), .ctl(ctl), .pins(pins),
    .conn(conn), .wire_level(wire_level)
  );

  // ============================================================
  // Shared tasks
  // ============================================================
  // One comparison; case inequality so unknowns never match
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // Wait n edges, then step past the edge so registers have landed
  task automatic edges(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : edges

  // Single place where the run ends
  task automatic conclude();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : conclude

  // Whole run needs well under 200 cycles; allow plenty more
  initial
  begin
    #8000;
    num_errors++;
    conclude();
  end

  // ============================================================
  // Main sequence
  // ============================================================
  initial
  begin
    edges(2);
    sys_rst = 1'b0;
    addr = 1'b1;  // Strap set once and left alone
    // Table rows: four edges covers the three-edge pin sync path
    foreach (ROWS[i])
    begin
      {party, flip, ctl, sel, vb} = {ROWS[i].party, ROWS[i].flip, ROWS[i].ctl,
                                     ROWS[i].sel, ROWS[i].vb};
      edges(4);
      chk("lines", {2'h0, ROWS[i].w}, {2'h0, wire_level});
      chk("status", {3'h0, ROWS[i].st}, {3'h0, status});
      chk("rp_level", 8'(ROWS[i].rp), 8'(rp_level));
      chk("vconn", {6'h0, ROWS[i].vc}, {6'h0, vconn_route});
      chk("address_bit", 8'h01, {7'h0, address_bit});
    end

    // Attached sink at high current, then select lowered at run time
    {party, flip, ctl, sel, vb} = {2'h1, 1'b0, 3'h2, 2'h3, 2'h3};
    edges(4);
    sel = 2'h2;
    edges(2);
    chk("rp_hold", 8'(tcs_pkg::TCS_ADV_TYPEC_HIGH), 8'(rp_level));
    edges(1);
    chk("rp_new", 8'(tcs_pkg::TCS_ADV_TYPEC_MEDIUM), 8'(rp_level));

    // Error recovery mid-connection releases every pin and VCONN one edge later
    ctl = 3'h6;
    edges(1);
    chk("err_lines", 8'h3f, {2'h0, wire_level});
    chk("err_vconn", 8'h00, {6'h0, vconn_route});

    // Recover, then detach: power path drops with the connection
    ctl = 3'h2;
    edges(4);
    chk("re_attach", 8'h26, {2'h0, wire_level});
    party = 2'h0;
    edges(1);
    chk("detach", 8'h3f, {2'h0, wire_level});

    // Clock enable low: a new sink is not taken until it rises again
    ce = 1'b0;
    party = 2'h1;
    edges(2);
    chk("ce_hold", 8'h3f, {2'h0, wire_level});
    ce = 1'b1;
    edges(1);
    chk("ce_run", 8'h26, {2'h0, wire_level});

    // Second reset while attached: all back to reset values
    party = 2'h1;
    edges(2);
    sys_rst = 1'b1;
    edges(1);
    chk("rst_lines", 8'h3f, {2'h0, wire_level});
    chk("rst_status", 8'h01, {3'h0, status});
    chk("rst_rp", 8'(tcs_pkg::TCS_ADV_USB_DEFAULT), 8'(rp_level));
    chk("rst_addr", 8'h00, {7'h0, address_bit});
    edges(1);
    sys_rst = 1'b0;
    edges(4);
    chk("post_rst", 8'h26, {2'h0, wire_level});
    conclude();
  end

endmodule : typec_source_pin_status_control_tb

`default_nettype wire
